// ==== serial_err_irq.sv ====
// Error detection, interrupt lines and autobaud write-back of the serial channel
//
// How it works
// - Successful autobaud overwrites mode field, odd bit and 13-bit baud reload.
// - Format codes map to mode 011/111/001 with odd bit per parity.
// - Rate steps zero to eight load reload 2,5,11,17,35,71,143,287,575.
// - Error line pulses in the same cycle as the receive line.
// - Async, framing check on, low stop bit: set framing flag, error interrupt.
// - Async parity modes, parity check on, mismatch: set parity flag, error.
// - Overrun check on, unread previous character: set overrun flag, error.
// - All six interrupt lines pulse for two clock periods.
// - Error flags stay set until software clears them.
// - Transmit-buffer interrupt pulses when holding data moves to the shifter.
// - Transmit interrupt before last async bit, after last sync bit.
// - Receive interrupt pulses when a frame enters the receive buffer.
// - Holding buffer accepts writes while the previous word shifts out.
// - Autobaud start interrupt on each start bit while enable, detect and start enables are set and detection is active.
// - Autobaud found after second character, and first when enabled.
// - Rate steps are divided clock over factors 48 up to 9216.
`timescale 1ns/10ps
`default_nettype none
module serial_err_irq
  import serial_err_pkg::*;
#(
  parameter int PULSE_LEN = IRQ_PULSE_CYC
) (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output var  logic [DATA_W-1:0]  reg_rdata_ff,
  input  wire logic               rxd,
  input  wire logic               rx_frame_done,
  input  wire logic [FRAME_W-1:0] rx_frame_data,
  input  wire logic               rx_stop_ok,
  input  wire logic               rx_parity_ok,
  input  wire logic               tx_shift_take,
  input  wire logic               tx_last_bit_async,
  input  wire logic               tx_frame_end_sync,
  input  wire logic               ab_first_char,
  input  wire logic               ab_done,
  input  wire logic [2:0]         ab_format,
  input  wire logic [3:0]         ab_rate,
  output var  logic               tx_shift_load_ff,
  output var  logic [FRAME_W-1:0] tx_shift_data_ff,
  output var  logic [MODE_W-1:0]  frame_mode_ff,
  output var  logic               odd_parity_ff,
  output var  logic               sync_mode_ff,
  output var  logic [BAUD_W-1:0]  baud_reload_ff,
  output var  logic               autobaud_active_ff,
  output wire logic               tx_buffer_irq,
  output wire logic               transmit_done_irq,
  output wire logic               receive_irq_line,
  output wire logic               error_irq_line,
  output wire logic               autobaud_start_irq,
  output wire logic               autobaud_found_irq,
  output var  logic               irq_ff
);

  if (PULSE_LEN < 1) begin : g_bad_len
    $error("serial_err_irq: PULSE_LEN must be at least 1");
  end

  // Control and status state
  logic                 framing_check_enable_ff;
  logic                 parity_check_enable_ff;
  logic                 overrun_check_enable_ff;
  logic                 framing_error_flag_ff;
  logic                 parity_error_flag_ff;
  logic                 overrun_error_flag_ff;
  logic [FRAME_W-1:0]   tx_holding_buffer_ff;
  logic                 tx_full_ff;
  logic [FRAME_W-1:0]   rx_holding_buffer_ff;
  logic                 rx_full_ff;
  logic [IRQ_N-1:0]     irq_stat_ff;
  logic [IRQ_N-1:0]     irq_en_ff;
  logic [AB_CTRL_W-1:0] ab_ctrl_ff;
  logic                 ab_first_seen_ff;
  logic                 ab_done_seen_ff;
  logic                 rxd_meta_ff;
  logic                 rxd_sync_ff;
  logic                 rxd_prev_ff;

  // Decoded bus strobes
  logic wr_ctrl;
  logic wr_baud;
  logic wr_txbuf;
  logic rd_rxbuf;
  logic wr_irq_clr;
  logic wr_irq_en;
  logic wr_ab_ctrl;

  assign wr_ctrl    = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_baud    = reg_wr && (reg_addr == OFS_BAUD);
  assign wr_txbuf   = reg_wr && (reg_addr == OFS_TXBUF);
  assign rd_rxbuf   = reg_rd && (reg_addr == OFS_RXBUF);
  assign wr_irq_clr = reg_wr && (reg_addr == OFS_IRQ_CLR);
  assign wr_irq_en  = reg_wr && (reg_addr == OFS_IRQ_EN);
  assign wr_ab_ctrl = reg_wr && (reg_addr == OFS_AB_CTRL);

  // Autobaud enables
  logic ab_en;
  logic ab_det_en;
  logic ab_st_en;
  logic ab_fc_en;

  assign ab_en     = ab_ctrl_ff[AB_EN_BIT];
  assign ab_det_en = ab_ctrl_ff[AB_DETEN_BIT];
  assign ab_st_en  = ab_ctrl_ff[AB_STEN_BIT];
  assign ab_fc_en  = ab_ctrl_ff[AB_FCDET_BIT];

  // Autobaud result decode
  logic             ab_fmt_ok;
  logic             ab_rate_ok;
  logic             ab_apply;
  logic [2:0]       ab_mode;
  logic             ab_odd;
  logic [BAUD_W-1:0] ab_reload;

  assign ab_fmt_ok  = (ab_format <= FMT_8_NOPAR);
  assign ab_rate_ok = (32'(ab_rate) < RATE_N);
  assign ab_apply   = ab_done && ab_en && ab_det_en && ab_fmt_ok && ab_rate_ok;

  always_comb begin
    ab_mode = MODE_8_NOPAR;
    ab_odd  = 1'b0;
    case (ab_format)
      FMT_7_EVEN: begin
        ab_mode = MODE_7_PAR;
      end
      FMT_7_ODD: begin
        ab_mode = MODE_7_PAR;
        ab_odd  = 1'b1;
      end
      FMT_8_EVEN: begin
        ab_mode = MODE_8_PAR;
      end
      FMT_8_ODD: begin
        ab_mode = MODE_8_PAR;
        ab_odd  = 1'b1;
      end
      default: begin
        ab_mode = MODE_8_NOPAR;
      end
    endcase
  end

  // Reload follows the divide factor of the detected step
  always_comb begin
    ab_reload = BAUD_RST;
    for (int i = 0; i < RATE_N; i++) begin
      if (32'(ab_rate) == i) begin
        ab_reload = BAUD_W'(RATE_DIV[i] / RELOAD_GRAIN - 1);
      end
    end
  end

  // Receive-side error detection
  logic has_parity;
  logic fe_evt;
  logic pe_evt;
  logic oe_evt;
  logic err_evt;

  assign has_parity = (frame_mode_ff == MODE_7_PAR) || (frame_mode_ff == MODE_8_PAR);
  assign fe_evt     = rx_frame_done && framing_check_enable_ff && !sync_mode_ff && !rx_stop_ok;
  assign pe_evt     = rx_frame_done && parity_check_enable_ff && !sync_mode_ff && has_parity
                      && !rx_parity_ok;
  assign oe_evt     = rx_frame_done && overrun_check_enable_ff && rx_full_ff && !rd_rxbuf;
  assign err_evt    = fe_evt || pe_evt || oe_evt;

  // Interrupt events
  logic             rxd_fall;
  logic             txbuf_evt;
  logic [IRQ_N-1:0] evt;

  assign rxd_fall  = rxd_prev_ff && !rxd_sync_ff;
  assign txbuf_evt = tx_full_ff && tx_shift_take;

  always_comb begin
    evt            = '0;
    evt[IRQ_TXBUF] = txbuf_evt;
    evt[IRQ_TX]    = sync_mode_ff ? tx_frame_end_sync : tx_last_bit_async;
    evt[IRQ_RX]    = rx_frame_done;
    evt[IRQ_ERR]   = err_evt;
    evt[IRQ_ABST]  = ab_en && ab_det_en && ab_st_en && autobaud_active_ff && rxd_fall;
    evt[IRQ_ABDET] = ab_en && (ab_apply || (ab_first_char && ab_fc_en));
  end

  // Six output lines, same latency for every source
  logic [IRQ_N-1:0] irq_line;

  for (genvar g = 0; g < IRQ_N; g++) begin : g_line
    pulse_stretch #(
      .LEN      (PULSE_LEN)
    ) u_stretch (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .trig     (evt[g]),
      .pulse_ff (irq_line[g])
    );
  end

  assign tx_buffer_irq      = irq_line[IRQ_TXBUF];
  assign transmit_done_irq  = irq_line[IRQ_TX];
  assign receive_irq_line   = irq_line[IRQ_RX];
  assign error_irq_line     = irq_line[IRQ_ERR];
  assign autobaud_start_irq = irq_line[IRQ_ABST];
  assign autobaud_found_irq = irq_line[IRQ_ABDET];

  // Receive line synchroniser and edge history
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rxd_meta_ff <= 1'b1;
      rxd_sync_ff <= 1'b1;
      rxd_prev_ff <= 1'b1;
    end else begin
      rxd_meta_ff <= rxd;
      rxd_sync_ff <= rxd_meta_ff;
      rxd_prev_ff <= rxd_sync_ff;
    end
  end

  // Frame mode and odd select: autobaud result wins over a software write
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      frame_mode_ff <= CTRL_RST[MODE_LSB +: MODE_W];
      odd_parity_ff <= CTRL_RST[ODD_BIT];
    end else if (ab_apply) begin
      frame_mode_ff <= ab_mode;
      odd_parity_ff <= ab_odd;
    end else if (wr_ctrl) begin
      frame_mode_ff <= reg_wdata[MODE_LSB +: MODE_W];
      odd_parity_ff <= reg_wdata[ODD_BIT];
    end
  end

  // Check enables and mode select
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      framing_check_enable_ff <= CTRL_RST[FEN_BIT];
      parity_check_enable_ff  <= CTRL_RST[PEN_BIT];
      overrun_check_enable_ff <= CTRL_RST[OEN_BIT];
      sync_mode_ff            <= CTRL_RST[SYNC_BIT];
    end else if (wr_ctrl) begin
      framing_check_enable_ff <= reg_wdata[FEN_BIT];
      parity_check_enable_ff  <= reg_wdata[PEN_BIT];
      overrun_check_enable_ff <= reg_wdata[OEN_BIT];
      sync_mode_ff            <= reg_wdata[SYNC_BIT];
    end
  end

  // Sticky error flags; software writes zero to clear, a new error wins
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      framing_error_flag_ff <= 1'b0;
      parity_error_flag_ff  <= 1'b0;
      overrun_error_flag_ff <= 1'b0;
    end else begin
      if (fe_evt) begin
        framing_error_flag_ff <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[FE_BIT]) begin
        framing_error_flag_ff <= 1'b0;
      end
      if (pe_evt) begin
        parity_error_flag_ff <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[PE_BIT]) begin
        parity_error_flag_ff <= 1'b0;
      end
      if (oe_evt) begin
        overrun_error_flag_ff <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[OE_BIT]) begin
        overrun_error_flag_ff <= 1'b0;
      end
    end
  end

  // Baud reload register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      baud_reload_ff <= BAUD_RST;
    end else if (ab_apply) begin
      baud_reload_ff <= ab_reload;
    end else if (wr_baud) begin
      baud_reload_ff <= reg_wdata[BAUD_W-1:0];
    end
  end

  // Transmit holding buffer; a write while full replaces the pending word
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_holding_buffer_ff <= '0;
      tx_full_ff           <= 1'b0;
    end else if (wr_txbuf) begin
      tx_holding_buffer_ff <= reg_wdata[FRAME_W-1:0];
      tx_full_ff           <= 1'b1;
    end else if (txbuf_evt) begin
      tx_full_ff           <= 1'b0;
    end
  end

  // Hand-off to the shifter
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_shift_load_ff <= 1'b0;
      tx_shift_data_ff <= '0;
    end else begin
      tx_shift_load_ff <= txbuf_evt;
      if (txbuf_evt) begin
        tx_shift_data_ff <= tx_holding_buffer_ff;
      end
    end
  end

  // Receive holding buffer; a new frame wins over a read in the same cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_holding_buffer_ff <= '0;
      rx_full_ff           <= 1'b0;
    end else if (rx_frame_done) begin
      rx_holding_buffer_ff <= rx_frame_data;
      rx_full_ff           <= 1'b1;
    end else if (rd_rxbuf) begin
      rx_full_ff           <= 1'b0;
    end
  end

  // Sticky interrupt status, enable and level output
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= evt | (irq_stat_ff & ~({IRQ_N{wr_irq_clr}} & reg_wdata[IRQ_N-1:0]));
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_ff <= '0;
    end else if (wr_irq_en) begin
      irq_en_ff <= reg_wdata[IRQ_N-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // Autobaud control and progress
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ab_ctrl_ff <= '0;
    end else if (wr_ab_ctrl) begin
      ab_ctrl_ff <= reg_wdata[AB_CTRL_W-1:0];
    end
  end

  // Detection runs from enabling until a result is applied
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      autobaud_active_ff <= 1'b0;
      ab_first_seen_ff   <= 1'b0;
      ab_done_seen_ff    <= 1'b0;
    end else if (wr_ab_ctrl) begin
      autobaud_active_ff <= reg_wdata[AB_EN_BIT] && reg_wdata[AB_DETEN_BIT];
      ab_first_seen_ff   <= 1'b0;
      ab_done_seen_ff    <= 1'b0;
    end else begin
      if (ab_apply) begin
        autobaud_active_ff <= 1'b0;
        ab_done_seen_ff    <= 1'b1;
      end
      if (ab_en && ab_first_char) begin
        ab_first_seen_ff <= 1'b1;
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      OFS_CTRL: begin
        rd_mux[MODE_LSB +: MODE_W] = frame_mode_ff;
        rd_mux[ODD_BIT]            = odd_parity_ff;
        rd_mux[FEN_BIT]            = framing_check_enable_ff;
        rd_mux[PEN_BIT]            = parity_check_enable_ff;
        rd_mux[OEN_BIT]            = overrun_check_enable_ff;
        rd_mux[SYNC_BIT]           = sync_mode_ff;
        rd_mux[FE_BIT]             = framing_error_flag_ff;
        rd_mux[PE_BIT]             = parity_error_flag_ff;
        rd_mux[OE_BIT]             = overrun_error_flag_ff;
        rd_mux[TXFULL_BIT]         = tx_full_ff;
        rd_mux[RXFULL_BIT]         = rx_full_ff;
      end
      OFS_BAUD: begin
        rd_mux[BAUD_W-1:0] = baud_reload_ff;
      end
      OFS_RXBUF: begin
        rd_mux[FRAME_W-1:0] = rx_holding_buffer_ff;
      end
      OFS_IRQ_STAT: begin
        rd_mux[IRQ_N-1:0] = irq_stat_ff;
      end
      OFS_IRQ_EN: begin
        rd_mux[IRQ_N-1:0] = irq_en_ff;
      end
      OFS_AB_CTRL: begin
        rd_mux[AB_CTRL_W-1:0] = ab_ctrl_ff;
      end
      OFS_AB_STAT: begin
        rd_mux[AB_BUSY_BIT]  = autobaud_active_ff;
        rd_mux[AB_FIRST_BIT] = ab_first_seen_ff;
        rd_mux[AB_DONE_BIT]  = ab_done_seen_ff;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_ff <= '0;
    end else if (reg_rd) begin
      reg_rdata_ff <= rd_mux;
    end else begin
      reg_rdata_ff <= '0;
    end
  end

endmodule
`default_nettype wire

// ==== serial_err_pkg.sv ====
// Constants, register map and field layout of the serial error and interrupt block
package serial_err_pkg;

  // Register bus
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 16;
  localparam logic [3:0]  OFS_CTRL      = 4'h0;
  localparam logic [3:0]  OFS_BAUD      = 4'h1;
  localparam logic [3:0]  OFS_TXBUF     = 4'h2;
  localparam logic [3:0]  OFS_RXBUF     = 4'h3;
  localparam logic [3:0]  OFS_IRQ_STAT  = 4'h4;
  localparam logic [3:0]  OFS_IRQ_CLR   = 4'h5;
  localparam logic [3:0]  OFS_IRQ_EN    = 4'h6;
  localparam logic [3:0]  OFS_AB_CTRL   = 4'h7;
  localparam logic [3:0]  OFS_AB_STAT   = 4'h8;

  // Control register fields
  localparam int          MODE_LSB      = 0;
  localparam int          MODE_W        = 3;
  localparam int          ODD_BIT       = 3;
  localparam int          FEN_BIT       = 4;
  localparam int          PEN_BIT       = 5;
  localparam int          OEN_BIT       = 6;
  localparam int          SYNC_BIT      = 7;
  localparam int          FE_BIT        = 8;
  localparam int          PE_BIT        = 9;
  localparam int          OE_BIT        = 10;
  localparam int          TXFULL_BIT    = 11;
  localparam int          RXFULL_BIT    = 12;
  localparam logic [7:0]  CTRL_RST      = 8'h00;

  // Baud reload register
  localparam int          BAUD_W        = 13;
  localparam logic [12:0] BAUD_RST      = 13'h0000;

  // Frame data width
  localparam int          FRAME_W       = 9;

  // Interrupt bit positions
  localparam int          IRQ_TXBUF     = 0;
  localparam int          IRQ_TX        = 1;
  localparam int          IRQ_RX        = 2;
  localparam int          IRQ_ERR       = 3;
  localparam int          IRQ_ABST      = 4;
  localparam int          IRQ_ABDET     = 5;
  localparam int          IRQ_N         = 6;
  localparam int          IRQ_PULSE_CYC = 2;

  // Autobaud control and status bits
  localparam int          AB_EN_BIT     = 0;
  localparam int          AB_DETEN_BIT  = 1;
  localparam int          AB_STEN_BIT   = 2;
  localparam int          AB_FCDET_BIT  = 3;
  localparam int          AB_CTRL_W     = 4;
  localparam int          AB_BUSY_BIT   = 0;
  localparam int          AB_FIRST_BIT  = 1;
  localparam int          AB_DONE_BIT   = 2;

  // Frame mode patterns
  localparam logic [2:0]  MODE_7_PAR    = 3'h3;
  localparam logic [2:0]  MODE_8_PAR    = 3'h7;
  localparam logic [2:0]  MODE_8_NOPAR  = 3'h1;

  // Detected format codes
  localparam logic [2:0]  FMT_7_EVEN    = 3'h0;
  localparam logic [2:0]  FMT_7_ODD     = 3'h1;
  localparam logic [2:0]  FMT_8_EVEN    = 3'h2;
  localparam logic [2:0]  FMT_8_ODD     = 3'h3;
  localparam logic [2:0]  FMT_8_NOPAR   = 3'h4;

  // Detectable rate steps, divide factor of each against the divided rate clock
  localparam int          RATE_N        = 9;
  localparam int          RATE_DIV [RATE_N] = '{48, 96, 192, 288, 576, 1152, 2304, 4608, 9216};
  localparam int          RELOAD_GRAIN  = 16;

endpackage

// ==== pulse_stretch.sv ====
// Stretches a one-cycle trigger into an output pulse of fixed length
`timescale 1ns/10ps
`default_nettype none
module pulse_stretch #(
  parameter int LEN = 2
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic trig,
  output var  logic pulse_ff
);
  localparam int CW = $clog2(LEN + 1);

  logic [CW-1:0] cnt_ff;

  if (LEN < 1) begin : g_bad_len
    $error("pulse_stretch: LEN must be at least 1");
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff   <= '0;
      pulse_ff <= 1'b0;
    end else if (trig) begin
      cnt_ff   <= CW'(LEN - 1);
      pulse_ff <= 1'b1;
    end else if (cnt_ff != '0) begin
      cnt_ff   <= cnt_ff - 1'b1;
      pulse_ff <= 1'b1;
    end else begin
      pulse_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== serial_err_monitor.sv ====
// Assertion checker for the serial error and interrupt block
`timescale 1ns/10ps
`default_nettype none
module serial_err_monitor
  import serial_err_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              reg_wr,
  input wire logic              rx_frame_done,
  input wire logic              tx_last_bit_async,
  input wire logic              tx_frame_end_sync,
  input wire logic              ab_first_char,
  input wire logic              ab_done,
  input wire logic [2:0]        ab_format,
  input wire logic [3:0]        ab_rate,
  input wire logic              tx_shift_load_ff,
  input wire logic              sync_mode_ff,
  input wire logic [BAUD_W-1:0] baud_reload_ff,
  input wire logic              autobaud_active_ff,
  input wire logic              tx_buffer_irq,
  input wire logic              transmit_done_irq,
  input wire logic              receive_irq_line,
  input wire logic              error_irq_line,
  input wire logic              autobaud_found_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Two cycles high, then low
  sequence hold2(s);
    s ##1 s ##1 !s;
  endsequence
  rx_pulse_a: assert property (rx_frame_done |=> hold2(receive_irq_line))
    else $error("receive line pulse wrong");
  err_pair_a: assert property (error_irq_line |-> receive_irq_line)
    else $error("error line without receive line");
  err_cause_a: assert property ($rose(error_irq_line) |-> $past(rx_frame_done))
    else $error("error line without frame end");
  txbuf_pulse_a: assert property (tx_shift_load_ff |-> hold2(tx_buffer_irq))
    else $error("buffer pulse wrong");
  tx_async_a: assert property (tx_last_bit_async && !sync_mode_ff |=> hold2(transmit_done_irq))
    else $error("async transmit pulse wrong");
  tx_sync_a: assert property (tx_frame_end_sync && sync_mode_ff |=> hold2(transmit_done_irq))
    else $error("sync transmit pulse wrong");
  baud_source_a: assert property ($changed(baud_reload_ff) |-> $past(ab_done) || $past(reg_wr))
    else $error("reload changed without cause");
  baud_slow_a: assert property (ab_done && autobaud_active_ff && ab_rate == 4'h8 && ab_format <= 3'h4
    |=> baud_reload_ff == 13'h023f) else $error("slowest reload wrong");
  found_cause_a: assert property ($rose(autobaud_found_irq) |-> $past(ab_done) || $past(ab_first_char))
    else $error("found pulse without cause");
endmodule
bind serial_err_irq serial_err_monitor i_serial_err_monitor (.clk_sys, .sys_rst, .reg_wr, .rx_frame_done,
  .tx_last_bit_async, .tx_frame_end_sync, .ab_first_char, .ab_done, .ab_format, .ab_rate, .tx_shift_load_ff,
  .sync_mode_ff, .baud_reload_ff, .autobaud_active_ff, .tx_buffer_irq, .transmit_done_irq, .receive_irq_line,
  .error_irq_line, .autobaud_found_irq);
`default_nettype wire

// ==== line_partner.sv ====
// Remote serial line model: start bit on the wire and frame end events
`timescale 1ns/10ps
`default_nettype none
module line_partner
  import serial_err_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               go,
  input  wire logic               stop_bad,
  input  wire logic               par_bad,
  input  wire logic [FRAME_W-1:0] data,
  output var  logic               rxd = 1'b1,
  output var  logic               rx_frame_done = 1'b0,
  output var  logic [FRAME_W-1:0] rx_frame_data = 9'h000,
  output var  logic               rx_stop_ok = 1'b0,
  output var  logic               rx_parity_ok = 1'b0
);
  logic [3:0] cnt_ff = 4'h0;
  // Qualifiers only hold with the done strobe; they toggle elsewhere
  always_ff @(posedge clk_sys) begin
    cnt_ff <= (go && cnt_ff == 4'h0) ? 4'hc : cnt_ff - {3'h0, cnt_ff != 4'h0};
    rxd <= (cnt_ff < 4'h9);
    rx_frame_done <= (cnt_ff == 4'h1);
    rx_stop_ok <= (cnt_ff == 4'h1) ? !stop_bad : !rx_stop_ok;
    rx_parity_ok <= (cnt_ff == 4'h1) ? !par_bad : !rx_parity_ok;
    rx_frame_data <= (cnt_ff == 4'h1) ? data : ~rx_frame_data;
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench of the serial error and interrupt block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import serial_err_pkg::*;
;
  localparam logic [12:0] RELOAD [9] = '{13'h002, 13'h005, 13'h00b, 13'h011, 13'h023, 13'h047, 13'h08f,
                                         13'h11f, 13'h23f};
  localparam logic [3:0]  EXP_FMT [5] = '{4'h3, 4'hb, 4'h7, 4'hf, 4'h1};
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [4:0]  ev = 5'h00;
  logic [2:0]  ab_format = 3'h0;
  logic [3:0]  ab_rate = 4'h0;
  logic        go = 1'b0;
  logic        sb = 1'b0;
  logic        pb = 1'b0;
  logic        ab_seen = 1'b0;
  logic [15:0] reg_rdata_ff;
  logic        rxd, rx_frame_done, rx_stop_ok, rx_parity_ok, tx_shift_load_ff, odd_parity_ff, sync_mode_ff;
  logic        autobaud_active_ff, tx_buffer_irq, transmit_done_irq, receive_irq_line, error_irq_line;
  logic        autobaud_start_irq, autobaud_found_irq, irq_ff;
  logic [8:0]  rx_frame_data, tx_shift_data_ff;
  logic [2:0]  frame_mode_ff;
  logic [12:0] baud_reload_ff;
  int          errors = 0;
  int          total_checks = 0;
  wire  [5:0]  irq_v = {autobaud_found_irq, autobaud_start_irq, error_irq_line, receive_irq_line,
                        transmit_done_irq, tx_buffer_irq};
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (autobaud_start_irq) ab_seen <= 1'b1;
  serial_err_irq i_serial_err_irq (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff,
    .rxd, .rx_frame_done, .rx_frame_data, .rx_stop_ok, .rx_parity_ok, .tx_shift_take(ev[0]),
    .tx_last_bit_async(ev[1]), .tx_frame_end_sync(ev[2]), .ab_first_char(ev[3]), .ab_done(ev[4]), .ab_format,
    .ab_rate, .tx_shift_load_ff, .tx_shift_data_ff, .frame_mode_ff, .odd_parity_ff, .sync_mode_ff,
    .baud_reload_ff, .autobaud_active_ff, .tx_buffer_irq, .transmit_done_irq, .receive_irq_line,
    .error_irq_line, .autobaud_start_irq, .autobaud_found_irq, .irq_ff);
  line_partner i_line_partner (.clk_sys, .go, .stop_bad(sb), .par_bad(pb), .data(9'h0a5), .rxd, .rx_frame_done,
    .rx_frame_data, .rx_stop_ok, .rx_parity_ok);
  task automatic stop_test;
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_ff;
  endtask
  // One-cycle event strobe; returns just after the edge that took it
  task automatic fire(input int k);
    @(posedge clk_sys);
    ev[k] <= 1'b1;
    @(posedge clk_sys);
    ev[k] <= 1'b0;
    #1;
  endtask
  task automatic see_pulse(input int b);
    chk(16'(irq_v[b]), 16'h0001);
    @(posedge clk_sys);
    #1 chk(16'(irq_v[b]), 16'h0001);
    @(posedge clk_sys);
    #1 chk(16'(irq_v[b]), 16'h0000);
  endtask
  task automatic frame(input logic s_bad, input logic p_bad, input logic err);
    @(posedge clk_sys);
    go <= 1'b1;
    sb <= s_bad;
    pb <= p_bad;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (20) begin
      @(posedge clk_sys);
      #1 if (receive_irq_line === 1'b1) break;
    end
    chk(16'(receive_irq_line), 16'h0001);
    chk(16'(error_irq_line), 16'(err));
  endtask
  task automatic t_regs;
    logic [15:0] d;
    rd(OFS_CTRL, d);
    chk(d, 16'h0000);
    rd(OFS_BAUD, d);
    chk(d, 16'h0000);
    rd(4'hf, d);
    chk(d, 16'h0000);
  endtask
  task automatic t_tx;
    logic [15:0] d;
    wr(OFS_TXBUF, 16'h01a5);
    fire(0);
    chk(16'(tx_shift_data_ff), 16'h01a5);
    chk(16'(tx_shift_load_ff), 16'h0001);
    see_pulse(IRQ_TXBUF);
    wr(OFS_TXBUF, 16'h00c3);
    rd(OFS_CTRL, d);
    chk(d & 16'h0800, 16'h0800);
    fire(0);
    chk(16'(tx_shift_data_ff), 16'h00c3);
    fire(1);
    see_pulse(IRQ_TX);
    wr(OFS_CTRL, 16'h0080);
    fire(2);
    see_pulse(IRQ_TX);
  endtask
  task automatic t_errors;
    logic [15:0] d;
    wr(OFS_IRQ_EN, 16'h0008);
    wr(OFS_CTRL, 16'h0077);
    frame(1'b1, 1'b0, 1'b1);
    @(posedge clk_sys);
    #1 chk(16'(irq_ff), 16'h0001);
    rd(OFS_IRQ_STAT, d);
    chk(d & 16'h000c, 16'h000c);
    wr(OFS_IRQ_CLR, 16'h003f);
    @(posedge clk_sys);
    #1 chk(16'(irq_ff), 16'h0000);
    rd(OFS_RXBUF, d);
    chk(d, 16'h00a5);
    frame(1'b0, 1'b1, 1'b1);
    rd(OFS_RXBUF, d);
    wr(OFS_IRQ_EN, 16'h0000);
    frame(1'b0, 1'b0, 1'b0);
    frame(1'b0, 1'b0, 1'b1);
    repeat (2) @(posedge clk_sys);
    #1 chk(16'(irq_ff), 16'h0000);
    rd(OFS_CTRL, d);
    chk(d & 16'h0700, 16'h0700);
    wr(OFS_CTRL, 16'h0077);
    rd(OFS_CTRL, d);
    chk(d & 16'h0700, 16'h0000);
    rd(OFS_RXBUF, d);
  endtask
  task automatic t_ab;
    for (int i = 0; i < 9; i++) begin
      wr(OFS_AB_CTRL, 16'h0003);
      ab_format <= 3'(i % 5);
      ab_rate <= 4'(i);
      fire(4);
      chk(16'(baud_reload_ff), 16'(RELOAD[i]));
      chk(16'({odd_parity_ff, frame_mode_ff}), 16'(EXP_FMT[i % 5]));
      see_pulse(IRQ_ABDET);
    end
    ab_format <= 3'h5;
    ab_rate <= 4'h0;
    fire(4);
    chk(16'(baud_reload_ff), 16'h023f);
    chk(16'(autobaud_found_irq), 16'h0000);
    wr(OFS_AB_CTRL, 16'h000b);
    fire(3);
    see_pulse(IRQ_ABDET);
    wr(OFS_AB_CTRL, 16'h0007);
    frame(1'b0, 1'b0, 1'b0);
    chk(16'(ab_seen), 16'h0001);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_tx;
    t_errors;
    t_ab;
    stop_test;
  end
  initial begin
    #200000;
    errors++;
    stop_test;
  end
endmodule
`default_nettype wire
